// >>> dv/scan_tester.sv
// Purpose: behavioural boundary-scan tester driving the test port
// Assumes: called at a falling edge; drives mode select and serial in there
// Notes:   serial in toggles outside shifts so stale data never looks valid
`timescale 1ns/1ps
module scan_tester (
    input  wire logic clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_en_i,
    output logic      tms_o,
    output logic      tdi_o
);
    initial begin
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    task automatic step(input logic m, input logic d);
        tms_o = m;
        tdi_o = d;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic reset_tap();
        repeat (5) step(1'b1, ~tdi_o);
    endtask

    // leaves the port in run-test-idle, one idle edge after update
    task automatic finish_scan();
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
        step(1'b0, ~tdi_o);
    endtask

    task automatic ir_scan(input logic [2:0] code, output logic [2:0] cap);
        step(1'b0, ~tdi_o);
        step(1'b1, ~tdi_o);
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
        step(1'b0, ~tdi_o);
        for (int k = 0; k < 3; k++) begin
            step(k == 2, code[k]);
            cap[k] = tdo_i;
        end
        finish_scan();
    endtask

    task automatic dr_scan(input logic [31:0] din, output logic [31:0] dout, output logic en_all);
        step(1'b0, ~tdi_o);
        step(1'b1, ~tdi_o);
        step(1'b0, ~tdi_o);
        step(1'b0, ~tdi_o);
        en_all = 1'b1;
        for (int k = 0; k < 32; k++) begin
            step(k == 31, din[k]);
            dout[k] = tdo_i;
            en_all  = en_all & tdo_en_i;
        end
        finish_scan();
    endtask
endmodule

// >>> dv/test_boundary_scan_test_registers.sv
// Purpose: self-checking bench for the boundary-scan test registers
// Assumes: boundary register shortened to 8 cells; 32-bit data scans, 3-bit instruction scans
// Notes:   inputs change on falling edges only
`timescale 1ns/1ps
module test_boundary_scan_test_registers;
    localparam logic [31:0] ID_WORD = {scan_pkg::ID_VER_DFLT, scan_pkg::ID_PART_DFLT, scan_pkg::ID_MFR_DFLT, 1'b1};
    typedef struct {
        logic [2:0]  code;
        logic [31:0] din;
        logic [31:0] dout;
        logic [1:0]  lat;
        logic [31:0] lat_exp;
    } row_t;

    logic        clk;
    logic        rst_n;
    logic [7:0]  pins;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_en;
    logic [7:0]  bsr_latch;
    logic [31:0] id_latch;
    logic [2:0]  instr;
    logic [2:0]  cap;
    logic [31:0] dout;
    logic        en_all;
    int          n_errors;
    int          comparisons;
    row_t        rows[8];

    scan_test_regs #(.BSR_LEN(8)) uut (
        .CLK_I(clk), .RESET_N_I(rst_n), .SCAN_MODE_SELECT_I(tms), .SCAN_SERIAL_IN_I(tdi),
        .PIN_SAMPLE_I(pins), .SCAN_SERIAL_OUT_O(tdo), .SCAN_SERIAL_OUT_EN_O(tdo_en),
        .BSR_LATCH_O(bsr_latch), .ID_LATCH_O(id_latch), .INSTR_O(instr));

    scan_tester tester (.clk_i(clk), .tdo_i(tdo), .tdo_en_i(tdo_en), .tms_o(tms), .tdi_o(tdi));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_instr(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    initial begin
        #100000;
        n_errors++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        pins  = 8'hC3;
        // bypass rows expect the captured zero ahead of the data
        rows[0] = '{scan_pkg::INS_EXTEST, 32'h1234_5678, 32'h3456_78C3, 2'd1, 32'h0000_0012};
        rows[1] = '{scan_pkg::INS_HIGHZ,  32'h8000_0001, 32'h0000_0002, 2'd0, 32'h0};
        rows[2] = '{scan_pkg::INS_CLAMP,  32'hF0F0_F0F0, 32'hE1E1_E1E0, 2'd0, 32'h0};
        rows[3] = '{scan_pkg::INS_SAMPLE, 32'hA5A5_5A5A, 32'hA55A_5AC3, 2'd1, 32'h0000_00A5};
        rows[4] = '{scan_pkg::INS_IDCODE, 32'hCAFE_F00D, ID_WORD,       2'd2, 32'hCAFE_F00D};
        rows[5] = '{scan_pkg::INS_BYPASS, 32'h0000_0001, 32'h0000_0002, 2'd0, 32'h0};
        rows[6] = '{3'h1,                 32'h4000_0000, 32'h8000_0000, 2'd0, 32'h0};
        rows[7] = '{3'h5,                 32'hFFFF_FFFF, 32'hFFFF_FFFE, 2'd0, 32'h0};
        repeat (16) @(negedge clk);
        cmp_instr(instr, scan_pkg::INS_IDCODE);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        tester.dr_scan(32'h0, dout, en_all);
        cmp_word(dout, ID_WORD);
        foreach (rows[i]) begin
            tester.ir_scan(rows[i].code, cap);
            cmp_instr(cap, scan_pkg::IR_CAPTURE);
            cmp_instr(instr, rows[i].code);
            tester.dr_scan(rows[i].din, dout, en_all);
            cmp_word(dout, rows[i].dout);
            cmp_bit(en_all, 1'b1);
            cmp_bit(tdo_en, 1'b0);
            if (rows[i].lat == 2'd1)
                cmp_word({24'h0, bsr_latch}, rows[i].lat_exp);
            if (rows[i].lat == 2'd2)
                cmp_word(id_latch, rows[i].lat_exp);
        end
        // leaving for reset state must reselect the identification path
        tester.reset_tap();
        repeat (2) @(negedge clk);
        cmp_instr(instr, scan_pkg::INS_IDCODE);
        tester.dr_scan(32'h0, dout, en_all);
        cmp_word(dout, ID_WORD);
        // second reset in mid-run clears the latches
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        cmp_word({24'h0, bsr_latch}, 32'h0);
        cmp_word(id_latch, 32'h0);
        cmp_bit(tdo, 1'b0);
        cmp_instr(instr, scan_pkg::INS_IDCODE);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        tester.dr_scan(32'h0, dout, en_all);
        cmp_word(dout, ID_WORD);
        cmp_bit(tdo_en, 1'b0);
        summarize();
    end
endmodule

// >>> hdl/scan_pkg.sv
// Purpose: shared constants for the boundary-scan test register block
// Assumes: 3-bit instruction register, 32-bit identification word
// Notes:   identity fields are arbitrary neutral values
package scan_pkg;
    localparam int          IR_W          = 3;
    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_HIGHZ     = 3'h2;
    localparam logic [2:0]  INS_CLAMP     = 3'h3;
    localparam logic [2:0]  INS_SAMPLE    = 3'h4;
    localparam logic [2:0]  INS_IDCODE    = 3'h6;
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    localparam logic [2:0]  IR_CAPTURE    = 3'h1;
    localparam int          ID_W          = 32;
    localparam int          ID_LSB_POS    = 0;
    localparam int          ID_MFR_LSB    = 1;
    localparam int          ID_MFR_W      = 11;
    localparam int          ID_PART_LSB   = 12;
    localparam int          ID_PART_W     = 16;
    localparam int          ID_VER_LSB    = 28;
    localparam int          ID_VER_W      = 4;
    // arbitrary identity values
    localparam logic [10:0] ID_MFR_DFLT   = 11'h5A5;
    localparam logic [15:0] ID_PART_DFLT  = 16'h1234;
    localparam logic [3:0]  ID_VER_DFLT   = 4'h2;
    localparam int          BSR_LEN_DFLT  = 16;
endpackage

// >>> hdl/scan_tap_fsm.sv
// Purpose: test access port state sequencer, steps on rising scan clock
// Assumes: mode select sampled on each rising edge
// Notes:   states follow the standard sixteen-state graph
`timescale 1ns/1ps
module scan_tap_fsm (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       tms_i,
    output logic [3:0]      state_o
);
    typedef enum logic [3:0] {
        S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3,
        S_SHD = 4'h4, S_E1D = 4'h5, S_PDR = 4'h6, S_E2D = 4'h7,
        S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'hA, S_SHI = 4'hB,
        S_E1I = 4'hC, S_PIR = 4'hD, S_E2I = 4'hE, S_UIR = 4'hF
    } tap_state_t;
    tap_state_t st_q;
    tap_state_t st_d;
    always_comb begin
        case (st_q)
            S_TLR:   st_d = tms_i ? S_TLR : S_RTI;
            S_RTI:   st_d = tms_i ? S_SDR : S_RTI;
            S_SDR:   st_d = tms_i ? S_SIR : S_CDR;
            S_CDR:   st_d = tms_i ? S_E1D : S_SHD;
            S_SHD:   st_d = tms_i ? S_E1D : S_SHD;
            S_E1D:   st_d = tms_i ? S_UDR : S_PDR;
            S_PDR:   st_d = tms_i ? S_E2D : S_PDR;
            S_E2D:   st_d = tms_i ? S_UDR : S_SHD;
            S_UDR:   st_d = tms_i ? S_SDR : S_RTI;
            S_SIR:   st_d = tms_i ? S_TLR : S_CIR;
            S_CIR:   st_d = tms_i ? S_E1I : S_SHI;
            S_SHI:   st_d = tms_i ? S_E1I : S_SHI;
            S_E1I:   st_d = tms_i ? S_UIR : S_PIR;
            S_PIR:   st_d = tms_i ? S_E2I : S_PIR;
            S_E2I:   st_d = tms_i ? S_UIR : S_SHI;
            S_UIR:   st_d = tms_i ? S_SDR : S_RTI;
            default: st_d = S_TLR;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_TLR;
        end else begin
            st_q <= st_d;
        end
    end
    assign state_o = st_q;
endmodule

// >>> hdl/scan_test_regs.sv
// Purpose: boundary-scan test data registers with instruction register
// Assumes: scan clock CLK_I is the test clock; inputs synchronous to it
// Notes:   falling-edge update latches are modelled as half-cycle-late
//          rising-edge updates to keep a single clock edge
//
// Operation
// - identification register: 32-bit shift stage plus 32-bit latched output
// - identification register selected by identification instruction or reset state
// - id word: 1, 11-bit maker code, 16-bit part, 4-bit version
// - one-bit bypass stage selected for bypass, clamp, high-impedance and the unassigned codes 1 and 5
// - boundary register: shift path plus latched output over all cells
// - 3-bit instruction register with the listed encodings
// - capture loads id word, pins or bypass zero into the selected stage, then shifted out during shift state
// - update state copies selected shift path into output latches
`timescale 1ns/1ps
module scan_test_regs #(
    parameter int          BSR_LEN  = scan_pkg::BSR_LEN_DFLT,
    parameter logic [10:0] MFR_CODE = scan_pkg::ID_MFR_DFLT,
    parameter logic [15:0] PART     = scan_pkg::ID_PART_DFLT,
    parameter logic [3:0]  VERSION  = scan_pkg::ID_VER_DFLT
) (
    input  wire logic               CLK_I,
    input  wire logic               RESET_N_I,
    input  wire logic               SCAN_MODE_SELECT_I,
    input  wire logic               SCAN_SERIAL_IN_I,
    input  wire logic [BSR_LEN-1:0] PIN_SAMPLE_I,
    output logic                    SCAN_SERIAL_OUT_O,
    output logic                    SCAN_SERIAL_OUT_EN_O,
    output logic [BSR_LEN-1:0]      BSR_LATCH_O,
    output logic [31:0]             ID_LATCH_O,
    output logic [2:0]              INSTR_O
);
    localparam logic [3:0] ST_TLR = 4'h0;
    localparam logic [3:0] ST_CDR = 4'h3;
    localparam logic [3:0] ST_SHD = 4'h4;
    localparam logic [3:0] ST_UDR = 4'h8;
    localparam logic [3:0] ST_CIR = 4'hA;
    localparam logic [3:0] ST_SHI = 4'hB;
    localparam logic [3:0] ST_UIR = 4'hF;

    localparam logic [31:0] ID_WORD = {VERSION, PART, MFR_CODE, 1'b1};

    logic                sync1_q;
    logic                sync2_q;
    logic [3:0]          tap_st;
    logic [3:0]          tap_prev_q;
    logic [2:0]          ir_sh_q, ir_sh_d;
    logic [2:0]          ir_q, ir_d;
    logic                byp_q, byp_d;
    logic [31:0]         id_sh_q, id_sh_d;
    logic [31:0]         id_lat_q, id_lat_d;
    logic [BSR_LEN-1:0]  bsr_sh_q, bsr_sh_d;
    logic [BSR_LEN-1:0]  bsr_lat_q, bsr_lat_d;
    logic                tdo_d, tdo_en_d;

    // release reset through two stages so removal is clean
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= 1'b1;
            sync2_q <= sync1_q;
        end
    end

    scan_tap_fsm u_tap (
        .clk_i   (CLK_I),
        .rst_n_i (sync2_q),
        .tms_i   (SCAN_MODE_SELECT_I),
        .state_o (tap_st)
    );

    function automatic logic sel_id(input logic [3:0] st, input logic [2:0] ir);
        sel_id = (st == ST_TLR) || (ir == scan_pkg::INS_IDCODE);
    endfunction

    function automatic logic sel_bsr(input logic [2:0] ir);
        sel_bsr = (ir == scan_pkg::INS_EXTEST) || (ir == scan_pkg::INS_SAMPLE);
    endfunction

    always_comb begin
        ir_sh_d   = ir_sh_q;
        ir_d      = ir_q;
        byp_d     = byp_q;
        id_sh_d   = id_sh_q;
        id_lat_d  = id_lat_q;
        bsr_sh_d  = bsr_sh_q;
        bsr_lat_d = bsr_lat_q;
        tdo_d     = 1'b0;
        tdo_en_d  = 1'b0;
        if (tap_st == ST_TLR) begin
            ir_d = scan_pkg::INS_IDCODE;
        end
        if (tap_st == ST_CIR) begin
            ir_sh_d = scan_pkg::IR_CAPTURE;
        end else if (tap_st == ST_SHI) begin
            ir_sh_d = {SCAN_SERIAL_IN_I, ir_sh_q[2:1]};
        end
        // update state entered last edge: act like the falling edge inside it
        if (tap_st == ST_UIR && tap_prev_q != ST_UIR) begin
            ir_d = ir_sh_q;
        end
        if (tap_st == ST_CDR) begin
            if (sel_id(tap_st, ir_q)) begin
                id_sh_d = ID_WORD;
            end else if (sel_bsr(ir_q)) begin
                bsr_sh_d = PIN_SAMPLE_I;
            end else begin
                byp_d = 1'b0;
            end
        end else if (tap_st == ST_SHD) begin
            if (sel_id(tap_st, ir_q)) begin
                id_sh_d = {SCAN_SERIAL_IN_I, id_sh_q[31:1]};
            end else if (sel_bsr(ir_q)) begin
                bsr_sh_d = {SCAN_SERIAL_IN_I, bsr_sh_q[BSR_LEN-1:1]};
            end else begin
                byp_d = SCAN_SERIAL_IN_I;
            end
        end
        if (tap_st == ST_UDR && tap_prev_q != ST_UDR) begin
            if (sel_id(tap_st, ir_q)) begin
                id_lat_d = id_sh_q;
            end else if (sel_bsr(ir_q)) begin
                bsr_lat_d = bsr_sh_q;
            end
        end
        // serial out changes after the rising edge; driven only while shifting
        // the stage being shifted out is the one before this edge's shift
        if (tap_st == ST_SHI) begin
            tdo_d    = ir_sh_q[0];
            tdo_en_d = 1'b1;
        end else if (tap_st == ST_SHD) begin
            tdo_en_d = 1'b1;
            if (sel_id(tap_st, ir_q)) begin
                tdo_d = id_sh_q[0];
            end else if (sel_bsr(ir_q)) begin
                tdo_d = bsr_sh_q[0];
            end else begin
                tdo_d = byp_q;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge sync2_q) begin
        if (!sync2_q) begin
            tap_prev_q        <= ST_TLR;
            ir_sh_q           <= 3'h0;
            ir_q              <= scan_pkg::INS_IDCODE;
            byp_q             <= 1'b0;
            id_sh_q           <= 32'h0000_0000;
            id_lat_q          <= 32'h0000_0000;
            bsr_sh_q          <= '0;
            bsr_lat_q         <= '0;
            SCAN_SERIAL_OUT_O    <= 1'b0;
            SCAN_SERIAL_OUT_EN_O <= 1'b0;
        end else begin
            tap_prev_q        <= tap_st;
            ir_sh_q           <= ir_sh_d;
            ir_q              <= ir_d;
            byp_q             <= byp_d;
            id_sh_q           <= id_sh_d;
            id_lat_q          <= id_lat_d;
            bsr_sh_q          <= bsr_sh_d;
            bsr_lat_q         <= bsr_lat_d;
            SCAN_SERIAL_OUT_O    <= tdo_d;
            SCAN_SERIAL_OUT_EN_O <= tdo_en_d;
        end
    end

    assign BSR_LATCH_O = bsr_lat_q;
    assign ID_LATCH_O  = id_lat_q;
    assign INSTR_O     = ir_q;

    sequence s_capture_id;
        (tap_st == ST_CDR) && sel_id(tap_st, ir_q);
    endsequence

    property p_id_capture;
        @(posedge CLK_I) disable iff (!sync2_q)
        s_capture_id |=> (id_sh_q == ID_WORD);
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id word not captured");

    property p_id_lsb;
        @(posedge CLK_I) disable iff (!sync2_q)
        s_capture_id ##1 (tap_st == ST_SHD) |=> (SCAN_SERIAL_OUT_O == 1'b1) && SCAN_SERIAL_OUT_EN_O;
    endproperty
    a_id_lsb: assert property (p_id_lsb) else $error("id lsb not first out");

    property p_reset_selects_id;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_TLR) |=> (ir_q == scan_pkg::INS_IDCODE);
    endproperty
    a_reset_selects_id: assert property (p_reset_selects_id) else $error("reset state did not select id");

    property p_bypass_zero;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_CDR) && (ir_q == scan_pkg::INS_BYPASS) |=> !byp_q;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) else $error("bypass capture not zero");

    property p_bypass_path;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_SHD) && ($past(tap_st) == ST_SHD)
        && (ir_q == scan_pkg::INS_HIGHZ || ir_q == scan_pkg::INS_CLAMP || ir_q == scan_pkg::INS_BYPASS)
        |=> SCAN_SERIAL_OUT_O == $past(SCAN_SERIAL_IN_I, 2);
    endproperty
    a_bypass_path: assert property (p_bypass_path) else $error("bypass path wrong");

    property p_id_update;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_UDR) && (tap_prev_q != ST_UDR) && (ir_q == scan_pkg::INS_IDCODE)
        |=> ID_LATCH_O == $past(id_sh_q);
    endproperty
    a_id_update: assert property (p_id_update) else $error("id latch not updated");

    property p_bsr_hold;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st != ST_UDR) |=> $stable(BSR_LATCH_O);
    endproperty
    a_bsr_hold: assert property (p_bsr_hold) else $error("boundary latch moved outside update");

    property p_ir_update;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_UIR) && (tap_prev_q != ST_UIR) |=> INSTR_O == $past(ir_sh_q);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not latched");

    property p_id_shift;
        @(posedge CLK_I) disable iff (!sync2_q)
        (tap_st == ST_SHD) && (ir_q == scan_pkg::INS_IDCODE) |=> id_sh_q[30:0] == $past(id_sh_q[31:1]);
    endproperty
    a_id_shift: assert property (p_id_shift) else $error("id shift stage wrong");
endmodule
